//--- dps_host.sv
// Host-side model that issues object dictionary accesses to the set-point block
`timescale 1ns/1ps
`default_nettype none

module dps_host (
  input  wire logic                 CLK_SYS,
  output var dps_pkg::dps_od_req_t  OD_REQ,
  input  wire dps_pkg::dps_od_rsp_t OD_RSP
);

  initial begin
    OD_REQ = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One access: held from a falling edge through the taking edge, answer read at the next falling edge
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                        output logic [31:0] rd, output logic er, output logic ak);
    @(negedge CLK_SYS);
    OD_REQ = {1'b1, w, i, s, d};
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    ak = OD_RSP.ack;
    er = OD_RSP.err;
    rd = OD_RSP.rdata;
    // Released fields flip so a stale value can never pass for a live one
    OD_REQ = {1'b0, ~w, ~i, ~s, ~d};
  endtask

endmodule

`default_nettype wire

//--- dps_pkg.sv
// Package for the direct position set-point logic: object indices, reset values, types
package dps_pkg;

  // Object dictionary indices
  localparam logic [15:0] IDX_CONTROL_WORD   = 16'h6040;
  localparam logic [15:0] IDX_STATUS_WORD    = 16'h6041;
  localparam logic [15:0] IDX_MODE_SELECT    = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISPLAY   = 16'h6061;
  localparam logic [15:0] IDX_TARGET_POS     = 16'h607A;
  localparam logic [15:0] IDX_RANGE_LIMITS   = 16'h607B;
  localparam logic [15:0] IDX_SOFT_LIMITS    = 16'h607D;

  // Sub-indices of the two limit arrays
  localparam logic [7:0]  SUB_COUNT          = 8'h00;
  localparam logic [7:0]  SUB_MIN            = 8'h01;
  localparam logic [7:0]  SUB_MAX            = 8'h02;
  localparam logic [31:0] LIMIT_ENTRY_COUNT  = 32'h0000_0002;

  // Reset values
  localparam logic [15:0] CONTROL_WORD_RST   = 16'h0000;
  localparam logic [7:0]  MODE_RST           = 8'h00;
  localparam logic [31:0] TARGET_POS_RST     = 32'h0000_0000;
  localparam logic [31:0] LIMIT_MIN_RST      = 32'h8000_0000;
  localparam logic [31:0] LIMIT_MAX_RST      = 32'h7FFF_FFFF;

  // Mode selector values (signed 8-bit)
  localparam logic [7:0]  MODE_DIRECT_TRIG   = 8'hFD;
  localparam logic [7:0]  MODE_DIRECT_FREE   = 8'hFC;

  // Control word fields
  localparam int          CW_QUICK_STOP_N    = 2;
  localparam int          CW_NEW_SETPOINT    = 4;
  localparam int          CW_CHANGE_IMMED    = 5;
  localparam int          CW_HALT            = 8;
  localparam logic [3:0]  CW_ENABLE_OP       = 4'hF;

  // Status word fields
  localparam int          SW_OP_ENABLED      = 2;
  localparam int          SW_QUICK_STOP_N    = 5;
  localparam int          SW_TARGET_REACHED  = 10;
  localparam int          SW_SETPOINT_ACK    = 12;

  // Object access request from the fieldbus side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } dps_od_req_t;

  // Object access answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dps_od_rsp_t;

  typedef enum logic [1:0] {
    MV_IDLE,
    MV_RUN,
    MV_QUEUED
  } dps_move_t;

endpackage

//--- dps_setpoint.sv
// Direct position set-point acceptance, limiting and sequencing
`timescale 1ns/1ps
`default_nettype none

module dps_setpoint (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_B,
  input  wire dps_pkg::dps_od_req_t OD_REQ,
  output var dps_pkg::dps_od_rsp_t  OD_RSP,
  input  wire logic signed [31:0]   POS_ACTUAL,
  input  wire logic [31:0]          POS_WINDOW,
  input  wire logic signed [31:0]   HOME_POSITION,
  output logic signed [31:0]        POS_DEMAND,
  output logic                      MOVE_ACTIVE,
  output logic [15:0]               STATUS_WORD
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic signed [32:0] clamp33(input logic signed [32:0] v,
                                                 input logic signed [32:0] lo,
                                                 input logic signed [32:0] hi);
    logic signed [32:0] r;
    r = v;
    if (r < lo) begin
      r = lo;
    end
    if (r > hi) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic signed [32:0] sx33(input logic [31:0] v);
    return {v[31], v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Object storage

  logic [15:0]        control_word_reg;
  logic [7:0]         mode_select_reg;
  logic [7:0]         mode_display_reg;
  logic [31:0]        target_pos_reg;
  logic [31:0]        range_min_reg;
  logic [31:0]        range_max_reg;
  logic [31:0]        soft_min_reg;
  logic [31:0]        soft_max_reg;
  logic signed [31:0] demand_reg;
  logic signed [31:0] pend_reg;
  logic               sp_ack_reg;
  logic               reached_reg;
  dps_pkg::dps_move_t move_reg;
  dps_pkg::dps_od_rsp_t rsp_reg;

  logic wr;
  logic cw_wr;
  logic tp_wr;
  logic enabled;
  logic trig_edge;
  logic trig_change;
  logic accept;
  logic immed;
  logic signed [31:0] sp_raw;
  logic signed [31:0] sp_lim;
  logic signed [32:0] soft_lo;
  logic signed [32:0] soft_hi;
  logic signed [32:0] pos_err;
  logic [32:0]        pos_err_abs;
  logic               in_window;
  logic               move_done;

  assign wr    = OD_REQ.valid & OD_REQ.write;
  assign cw_wr = wr & (OD_REQ.index == dps_pkg::IDX_CONTROL_WORD);
  assign tp_wr = wr & (OD_REQ.index == dps_pkg::IDX_TARGET_POS);

  // Halt (bit 8) takes no part here; quick stop and enable gate all motion
  assign enabled = (control_word_reg[3:0] == dps_pkg::CW_ENABLE_OP);

  // Edge against the bit held from the previous write
  assign trig_edge = (mode_select_reg == dps_pkg::MODE_DIRECT_TRIG) & cw_wr
                   & OD_REQ.wdata[dps_pkg::CW_NEW_SETPOINT]
                   & ~control_word_reg[dps_pkg::CW_NEW_SETPOINT];

  // Untriggered mode: a write that changes the target is the trigger
  assign trig_change = (mode_select_reg == dps_pkg::MODE_DIRECT_FREE) & tp_wr
                     & (OD_REQ.wdata != target_pos_reg);

  // Triggered mode takes the stored target; untriggered takes the new value
  assign sp_raw = trig_change ? $signed(OD_REQ.wdata) : $signed(target_pos_reg);
  assign immed  = trig_edge ? OD_REQ.wdata[dps_pkg::CW_CHANGE_IMMED]
                            : control_word_reg[dps_pkg::CW_CHANGE_IMMED];

  // Soft limits are home-relative; range limits applied last keep the result in 32 bits
  assign soft_lo = sx33(soft_min_reg) + sx33(HOME_POSITION);
  assign soft_hi = sx33(soft_max_reg) + sx33(HOME_POSITION);
  assign sp_lim  = 32'(clamp33(clamp33(sx33(sp_raw), soft_lo, soft_hi),
                               sx33(range_min_reg), sx33(range_max_reg)));

  // A third set point without change-immediately while two are held is refused; the host waits on acknowledge
  assign accept = enabled & control_word_reg[dps_pkg::CW_QUICK_STOP_N]
                & (trig_edge | trig_change) & (immed | (move_reg != dps_pkg::MV_QUEUED));

  assign pos_err     = sx33(POS_ACTUAL) - sx33(demand_reg);
  assign pos_err_abs = pos_err[32] ? 33'(-pos_err) : 33'(pos_err);
  assign in_window   = (pos_err_abs <= {1'b0, POS_WINDOW});
  assign move_done   = (move_reg != dps_pkg::MV_IDLE) & in_window;

  ////////////////////////////////////////////////////////////////////////////
  // Object writes

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      control_word_reg <= dps_pkg::CONTROL_WORD_RST;
      mode_select_reg  <= dps_pkg::MODE_RST;
    end else if (cw_wr) begin
      control_word_reg <= OD_REQ.wdata[15:0];
    end else if (wr && OD_REQ.index == dps_pkg::IDX_MODE_SELECT) begin
      mode_select_reg  <= OD_REQ.wdata[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      target_pos_reg <= dps_pkg::TARGET_POS_RST;
    end else if (tp_wr) begin
      target_pos_reg <= OD_REQ.wdata;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      range_min_reg <= dps_pkg::LIMIT_MIN_RST;
      range_max_reg <= dps_pkg::LIMIT_MAX_RST;
      soft_min_reg  <= dps_pkg::LIMIT_MIN_RST;
      soft_max_reg  <= dps_pkg::LIMIT_MAX_RST;
    end else if (wr && OD_REQ.index == dps_pkg::IDX_RANGE_LIMITS) begin
      if (OD_REQ.subindex == dps_pkg::SUB_MIN) begin
        range_min_reg <= OD_REQ.wdata;
      end else if (OD_REQ.subindex == dps_pkg::SUB_MAX) begin
        range_max_reg <= OD_REQ.wdata;
      end
    end else if (wr && OD_REQ.index == dps_pkg::IDX_SOFT_LIMITS) begin
      if (OD_REQ.subindex == dps_pkg::SUB_MIN) begin
        soft_min_reg <= OD_REQ.wdata;
      end else if (OD_REQ.subindex == dps_pkg::SUB_MAX) begin
        soft_max_reg <= OD_REQ.wdata;
      end
    end
  end

  // Display lags the selector by one cycle; the set-point logic obeys the selector directly
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      mode_display_reg <= dps_pkg::MODE_RST;
    end else begin
      mode_display_reg <= mode_select_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Move sequencing

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      move_reg   <= dps_pkg::MV_IDLE;
      demand_reg <= '0;
      pend_reg   <= '0;
    end else if (!enabled || !control_word_reg[dps_pkg::CW_QUICK_STOP_N]) begin
      // Disabled or quick stop: hold the axis where it is and drop the queue
      move_reg   <= dps_pkg::MV_IDLE;
      demand_reg <= POS_ACTUAL;
    end else begin
      case (move_reg)
        dps_pkg::MV_IDLE: begin
          if (accept) begin
            move_reg   <= dps_pkg::MV_RUN;
            demand_reg <= sp_lim;
          end
        end
        dps_pkg::MV_RUN: begin
          if (accept && immed) begin
            demand_reg <= sp_lim;
          end else if (accept) begin
            move_reg <= dps_pkg::MV_QUEUED;
            pend_reg <= sp_lim;
          end else if (move_done) begin
            move_reg <= dps_pkg::MV_IDLE;
          end
        end
        dps_pkg::MV_QUEUED: begin
          if (accept) begin
            move_reg   <= dps_pkg::MV_RUN;
            demand_reg <= sp_lim;
          end else if (move_done) begin
            move_reg   <= dps_pkg::MV_RUN;
            demand_reg <= pend_reg;
          end
        end
        default: begin
          move_reg <= dps_pkg::MV_IDLE;
        end
      endcase
    end
  end

  // Acceptance wins over completion in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      sp_ack_reg <= 1'b0;
    end else if (accept) begin
      sp_ack_reg <= 1'b1;
    end else if (move_done || !enabled) begin
      sp_ack_reg <= 1'b0;
    end
  end

  // Not reached while a queued move still waits
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      reached_reg <= 1'b0;
    end else begin
      reached_reg <= in_window & (move_reg != dps_pkg::MV_QUEUED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Object reads

  always_comb begin
    STATUS_WORD = '0;
    STATUS_WORD[dps_pkg::SW_OP_ENABLED]     = enabled;
    STATUS_WORD[dps_pkg::SW_QUICK_STOP_N]   = control_word_reg[dps_pkg::CW_QUICK_STOP_N];
    STATUS_WORD[dps_pkg::SW_TARGET_REACHED] = reached_reg;
    STATUS_WORD[dps_pkg::SW_SETPOINT_ACK]   = sp_ack_reg;
  end

  // Unknown objects, bad sub-indices of the limit arrays and writes to read-only entries answer with err
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack   <= OD_REQ.valid;
      rsp_reg.err   <= 1'b0;
      rsp_reg.rdata <= '0;
      if (OD_REQ.valid) begin
        case (OD_REQ.index)
          dps_pkg::IDX_CONTROL_WORD: rsp_reg.rdata <= {16'h0000, control_word_reg};
          dps_pkg::IDX_STATUS_WORD: begin
            rsp_reg.rdata <= {16'h0000, STATUS_WORD};
            rsp_reg.err   <= OD_REQ.write;
          end
          dps_pkg::IDX_MODE_SELECT: rsp_reg.rdata <= {{24{mode_select_reg[7]}}, mode_select_reg};
          dps_pkg::IDX_MODE_DISPLAY: begin
            rsp_reg.rdata <= {{24{mode_display_reg[7]}}, mode_display_reg};
            rsp_reg.err   <= OD_REQ.write;
          end
          dps_pkg::IDX_TARGET_POS: rsp_reg.rdata <= target_pos_reg;
          dps_pkg::IDX_RANGE_LIMITS, dps_pkg::IDX_SOFT_LIMITS: begin
            case (OD_REQ.subindex)
              dps_pkg::SUB_COUNT: begin
                rsp_reg.rdata <= dps_pkg::LIMIT_ENTRY_COUNT;
                rsp_reg.err   <= OD_REQ.write;
              end
              dps_pkg::SUB_MIN: rsp_reg.rdata <= (OD_REQ.index == dps_pkg::IDX_RANGE_LIMITS) ?
                                                  range_min_reg : soft_min_reg;
              dps_pkg::SUB_MAX: rsp_reg.rdata <= (OD_REQ.index == dps_pkg::IDX_RANGE_LIMITS) ?
                                                  range_max_reg : soft_max_reg;
              default: rsp_reg.err <= 1'b1;
            endcase
          end
          default: rsp_reg.err <= 1'b1;
        endcase
      end
    end
  end

  assign OD_RSP      = rsp_reg;
  assign POS_DEMAND  = demand_reg;
  assign MOVE_ACTIVE = (move_reg != dps_pkg::MV_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_trig_edge_only: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (accept && mode_select_reg == dps_pkg::MODE_DIRECT_TRIG) |->
      (cw_wr && !control_word_reg[dps_pkg::CW_NEW_SETPOINT]))
    else $error("triggered set point taken without a rising edge");

  chk_no_edge_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    $rose(sp_ack_reg) && mode_select_reg == dps_pkg::MODE_DIRECT_TRIG |->
      $past(OD_REQ.wdata[dps_pkg::CW_NEW_SETPOINT]) && $past(cw_wr))
    else $error("acknowledge rose without a new set point edge");

  chk_free_change: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (trig_change && accept && move_reg == dps_pkg::MV_IDLE) |=>
      (POS_DEMAND == $past(sp_lim)) && MOVE_ACTIVE)
    else $error("changed target did not start a move");

  chk_immed_start: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (accept && immed && move_reg != dps_pkg::MV_IDLE) |=>
      (POS_DEMAND == $past(sp_lim)) && move_reg == dps_pkg::MV_RUN)
    else $error("immediate set point did not replace the running move");

  chk_queue_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (accept && !immed && move_reg == dps_pkg::MV_RUN) |=>
      $stable(POS_DEMAND) && move_reg == dps_pkg::MV_QUEUED)
    else $error("queued set point disturbed the running move");

  chk_range_clamp: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    accept |-> (sp_lim >= $signed(range_min_reg)) && (sp_lim <= $signed(range_max_reg)))
    else $error("set point outside range limits");

  chk_soft_clamp: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (accept && soft_lo <= soft_hi && soft_lo >= sx33(range_min_reg) && soft_hi <= sx33(range_max_reg)) |->
      (sx33(sp_lim) >= soft_lo) && (sx33(sp_lim) <= soft_hi))
    else $error("set point outside home-relative soft limits");

  chk_mode_display: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    ##1 (mode_display_reg == $past(mode_select_reg)))
    else $error("mode display does not follow the mode in effect");

  chk_ack_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (move_done && !accept && enabled) |=> !sp_ack_reg)
    else $error("acknowledge not cleared on move completion");

  chk_reached_win: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    STATUS_WORD[dps_pkg::SW_TARGET_REACHED] |-> $past(sx33(POS_ACTUAL) - sx33(POS_DEMAND) <= $signed({1'b0, POS_WINDOW})
      && sx33(POS_DEMAND) - sx33(POS_ACTUAL) <= $signed({1'b0, POS_WINDOW})))
    else $error("target reached shown outside the position window");

endmodule

`default_nettype wire

//--- dps_setpoint_bench.sv
// Self-checking bench for the direct position set-point block
`timescale 1ns/1ps
`default_nettype none

module dps_setpoint_bench;

  logic                 clk_sys;
  logic                 rst_b;
  dps_pkg::dps_od_req_t od_req;
  dps_pkg::dps_od_rsp_t od_rsp;
  logic signed [31:0]   pos_act;
  logic [31:0]          pos_win;
  logic signed [31:0]   home_pos;
  logic signed [31:0]   pos_dem;
  logic                 move_act;
  logic [15:0]          sw;
  logic [31:0]          rdv;
  int                   n_errors;
  int                   n_tests;
  int                   cyc;

  dps_setpoint u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .OD_REQ(od_req), .OD_RSP(od_rsp),
    .POS_ACTUAL(pos_act), .POS_WINDOW(pos_win), .HOME_POSITION(home_pos), .POS_DEMAND(pos_dem),
    .MOVE_ACTIVE(move_act), .STATUS_WORD(sw));
  dps_host u_host (.CLK_SYS(clk_sys), .OD_REQ(od_req), .OD_RSP(od_rsp));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                    input logic e);
    logic ak;
    logic er;
    u_host.access(w, i, s, d, rdv, er, ak);
    chk("ack", 32'h1, {31'h0, ak});
    chk("err", {31'h0, e}, {31'h0, er});
  endtask

  task automatic rdchk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    od(1'b0, i, s, 32'h0, 1'b0);
    chk("rdata", e, rdv);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h0);
    // With enable off the demand tracks the actual position, so target reached is already up
    rdchk(dps_pkg::IDX_STATUS_WORD, 8'h00, 32'h400);
    rdchk(dps_pkg::IDX_MODE_SELECT, 8'h00, 32'h0);
    rdchk(dps_pkg::IDX_MODE_DISPLAY, 8'h00, 32'h0);
    rdchk(dps_pkg::IDX_TARGET_POS, 8'h00, 32'h0);
    rdchk(dps_pkg::IDX_RANGE_LIMITS, 8'h00, 32'h2);
    rdchk(dps_pkg::IDX_RANGE_LIMITS, 8'h01, 32'h8000_0000);
    rdchk(dps_pkg::IDX_RANGE_LIMITS, 8'h02, 32'h7FFF_FFFF);
    rdchk(dps_pkg::IDX_SOFT_LIMITS, 8'h01, 32'h8000_0000);
    rdchk(dps_pkg::IDX_SOFT_LIMITS, 8'h02, 32'h7FFF_FFFF);
    od(1'b1, dps_pkg::IDX_STATUS_WORD, 8'h00, 32'hFFFF, 1'b1);
    od(1'b1, dps_pkg::IDX_MODE_DISPLAY, 8'h00, 32'h3, 1'b1);
    od(1'b1, dps_pkg::IDX_RANGE_LIMITS, 8'h00, 32'h5, 1'b1);
    od(1'b0, dps_pkg::IDX_SOFT_LIMITS, 8'h03, 32'h0, 1'b1);
    od(1'b1, 16'h1234, 8'h00, 32'h0, 1'b1);
    chk("move", 32'h0, {31'h0, move_act});
  endtask

  task automatic t_trig();
    pos_act = 32'hFFFE_7960;
    od(1'b1, dps_pkg::IDX_MODE_SELECT, 8'h00, 32'hFD, 1'b0);
    rdchk(dps_pkg::IDX_MODE_DISPLAY, 8'h00, 32'hFFFF_FFFD);
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'h3E8, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h0F, 1'b0);
    chk("no edge", 32'h0, {31'h0, move_act});
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h1F, 1'b0);
    chk("demand", 32'h3E8, pos_dem);
    chk("ack", 32'h1, {31'h0, sw[12]});
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h10F, 1'b0);
    chk("halt", 32'h1, {31'h0, move_act});
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'h7D0, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h1F, 1'b0);
    chk("queued", 32'h3E8, pos_dem);
    // A third point while two are held is dropped; host must wait for ack to fall
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h0F, 1'b0);
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'hBB8, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h1F, 1'b0);
    @(negedge clk_sys);
    pos_act = 32'h3E8;
    for (int k = 0; k < 8 && sw[12] !== 1'b0; k++) @(negedge clk_sys);
    chk("ack low", 32'h0, {31'h0, sw[12]});
    chk("next", 32'h7D0, pos_dem);
    pos_act = 32'h7D2;
    for (int k = 0; k < 8 && move_act !== 1'b0; k++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
    chk("idle", 32'h0, {31'h0, move_act});
    chk("reached", 32'h1, {31'h0, sw[10]});
    pos_act = 32'hFFFE_7960;
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h0F, 1'b0);
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'h1388, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h1F, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h0F, 1'b0);
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'h1770, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h3F, 1'b0);
    chk("immed", 32'h1770, pos_dem);
    chk("far", 32'h0, {31'h0, sw[10]});
    rdchk(dps_pkg::IDX_STATUS_WORD, 8'h00, 32'h1024);
  endtask

  task automatic t_free();
    od(1'b1, dps_pkg::IDX_MODE_SELECT, 8'h00, 32'hFC, 1'b0);
    rdchk(dps_pkg::IDX_MODE_DISPLAY, 8'h00, 32'hFFFF_FFFC);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h2F, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h3F, 1'b0);
    chk("bit4 ign", 32'h1770, pos_dem);
    pos_act = 32'h1770;
    repeat (2) @(negedge clk_sys);
    chk("done", 32'h0, {31'h0, move_act});
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'h1B58, 1'b0);
    chk("changed", 32'h1B58, pos_dem);
  endtask

  task automatic t_lim();
    home_pos = 32'h64;
    od(1'b1, dps_pkg::IDX_MODE_SELECT, 8'h00, 32'hFD, 1'b0);
    od(1'b1, dps_pkg::IDX_SOFT_LIMITS, 8'h01, 32'hFFFF_FFCE, 1'b0);
    od(1'b1, dps_pkg::IDX_SOFT_LIMITS, 8'h02, 32'h32, 1'b0);
    od(1'b1, dps_pkg::IDX_RANGE_LIMITS, 8'h01, 32'h0, 1'b0);
    od(1'b1, dps_pkg::IDX_RANGE_LIMITS, 8'h02, 32'h78, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h2F, 1'b0);
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'h1F4, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h3F, 1'b0);
    chk("clamp hi", 32'h78, pos_dem);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h2F, 1'b0);
    od(1'b1, dps_pkg::IDX_TARGET_POS, 8'h00, 32'hFFFF_FE0C, 1'b0);
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h3F, 1'b0);
    chk("clamp lo", 32'h32, pos_dem);
    // Quick stop (bit 2 low, enable dropped too) ends the move before its window is reached
    od(1'b1, dps_pkg::IDX_CONTROL_WORD, 8'h00, 32'h2B, 1'b0);
    pos_act = 32'hFFFF_FFB3;
    repeat (3) @(negedge clk_sys);
    chk("qstop", 32'hFFFF_FFB3, pos_dem);
    chk("ack clr", 32'h0, {31'h0, sw[12]});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    rst_b = 1'b0;
    pos_act = 32'h0;
    pos_win = 32'h5;
    home_pos = 32'h0;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset();
    t_trig();
    t_free();
    t_lim();
    tally_and_finish();
  end

endmodule

`default_nettype wire
